/* File: src/flash_device.sv */
// flash device end: command decoder, registers, read streams
// Operation
// - bytes move msb first, sampled on rising clock
// - 03h read, 0Bh fast, 3Bh two-line read
// - host ends write commands on byte boundary
// - 05h/35h stream status/config bytes repeatedly
// - 01h loads status, optional second config
// - 30h clears both failure flags
// - B9h sleeps; bare ABh wakes
// - ABh plus three dummies wakes, streams signature
// - 42h plus address programs one byte
// - 4Bh address, dummy, streams one-time area
// - host sends opcode, 24-bit address, slow clock
// - single-line data changes on falling edge
// - address steps per byte, wraps to zero
// - chip select high stops output at once
// - array reads ignored while busy
// - fast read has one dummy byte
// - two-line read drives two bits per fall
// - four-line read drives four bits per fall
// - host releases lines before first data fall
// - four-line mode needs quad enable bit
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs.svh"
module flash_device #(
   parameter logic [7:0] SIGNATURE = 8'h5A // arbitrary value
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   flash_if.device link,
   output logic [7:0] status_out,
   output logic [7:0] config_out,
   output logic sleep_out
);
   import flash_pkg::*;

   // ************************************
   // pin synchronisers
   // ************************************
   logic [5:0] s1_q, s2_q, s3_q, f_q, fp_q, f_d;
   logic cs_hi, rise, fall, cs_up;

   // three stages; a level counts once stages two and three agree
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_q <= `PIN_IDLE;
         s2_q <= `PIN_IDLE;
         s3_q <= `PIN_IDLE;
         f_q <= `PIN_IDLE;
         fp_q <= `PIN_IDLE;
      end else begin
         s1_q <= {link.cs_n, link.sck, link.io};
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= f_d;
         fp_q <= f_q;
      end
   end

   // edges of the filtered levels; clock edges count only inside a frame
   assign f_d = (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
   assign cs_hi = f_q[5];
   assign cs_up = f_q[5] & ~fp_q[5];
   assign rise = f_q[4] & ~fp_q[4] & ~cs_hi;
   assign fall = ~f_q[4] & fp_q[4] & ~cs_hi;

   // ************************************
   // frame decoder
   // ************************************
   dev_state_t st_q, cmd_next;
   logic [2:0] bit_q;
   logic [1:0] byte_q;
   logic [1:0] wcnt_q;
   logic [7:0] shin_q, op_q, wb0_q, wb1_q, nb;
   logic [23:0] addr_q, addr_step;
   logic [7:0] sr_q, cr_q, status, fetch;
   logic [7:0] busy_q;
   logic sleep_q, busy, qe, byte_done, load, exec, wrr_go, otp_go;
   logic [7:0] otp_q [0:`OTP_BYTES-1];

   assign nb = {shin_q[6:0], f_q[0]};
   assign byte_done = rise && bit_q == 3'h7;
   assign busy = busy_q != 8'h00;
   assign qe = cr_q[`CR_QUAD_ENABLE_BIT];

   // where the opcode leads; sleeping only answers the wake opcode
   always_comb begin
      cmd_next = ST_SKIP;
      if (!sleep_q || nb == `OP_WAKE_AND_SIGNATURE) begin
         case (nb)
            `OP_STATUS_FETCH, `OP_CONFIG_FETCH: cmd_next = ST_DOUT;
            `OP_REGISTER_WRITE, `OP_FAIL_FLAG_CLEAR, `OP_DEEP_SLEEP_ENTER: cmd_next = ST_DIN;
            `OP_WAKE_AND_SIGNATURE: cmd_next = ST_DUMMY;
            `OP_OTP_PROGRAM, `OP_OTP_READ: cmd_next = ST_ADDR;
            `OP_READ, `OP_FAST_READ, `OP_TWO_LINE_READ: cmd_next = busy ? ST_SKIP : ST_ADDR;
            `OP_FOUR_LINE_READ: cmd_next = (busy || !qe) ? ST_SKIP : ST_ADDR;
            default: cmd_next = ST_SKIP;
         endcase
      end
   end

   // address step; array wraps at the top, one-time area wraps by index width
   always_comb begin
      addr_step = addr_q + 24'h000001;
      if (op_q != `OP_OTP_READ && addr_q == `ARRAY_TOP) begin
         addr_step = 24'h000000;
      end
   end

   // opcode, address and data bytes; state, bit, byte and write counts restart when the frame ends
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= ST_CMD;
         bit_q <= 3'h0;
         byte_q <= 2'h0;
         wcnt_q <= 2'h0;
         shin_q <= 8'h00;
         op_q <= 8'h00;
         wb0_q <= 8'h00;
         wb1_q <= 8'h00;
         addr_q <= 24'h000000;
      end else if (cs_hi) begin
         st_q <= ST_CMD;
         bit_q <= 3'h0;
         byte_q <= 2'h0;
         wcnt_q <= 2'h0;
      end else if (rise) begin
         bit_q <= bit_q + 3'h1;
         shin_q <= nb;
         if (byte_done) begin
            case (st_q)
               ST_CMD: begin
                  op_q <= nb;
                  st_q <= cmd_next;
               end
               ST_ADDR: begin
                  addr_q <= {addr_q[15:0], nb};
                  byte_q <= byte_q + 2'h1;
                  if (byte_q == 2'h2) begin
                     byte_q <= 2'h0;
                     if (op_q == `OP_READ) st_q <= ST_DOUT;
                     else if (op_q == `OP_OTP_PROGRAM) st_q <= ST_DIN;
                     else st_q <= ST_DUMMY;
                  end
               end
               ST_DUMMY: begin
                  byte_q <= byte_q + 2'h1;
                  if (byte_q == 2'(op_dummy(op_q) - 2'h1)) st_q <= ST_DOUT;
               end
               ST_DIN: begin
                  if (wcnt_q != 2'h3) wcnt_q <= wcnt_q + 2'h1;
                  if (wcnt_q == 2'h0) wb0_q <= nb;
                  if (wcnt_q == 2'h1) wb1_q <= nb;
               end
               default: begin
               end
            endcase
         end
      end else if (load) begin
         if (op_q == `OP_OTP_READ || !(op_q == `OP_STATUS_FETCH ||
             op_q == `OP_CONFIG_FETCH || op_q == `OP_WAKE_AND_SIGNATURE)) begin
            addr_q <= addr_step;
         end
      end
   end

   // ************************************
   // registers and power state
   // ************************************
   // write commands take effect only when the frame ends on a byte boundary
   assign exec = cs_up && bit_q == 3'h0 && st_q == ST_DIN;
   assign wrr_go = exec && op_q == `OP_REGISTER_WRITE && !busy &&
                   (wcnt_q == 2'h1 || wcnt_q == 2'h2);
   assign otp_go = exec && op_q == `OP_OTP_PROGRAM && !busy && wcnt_q == 2'h1;
   assign status = {sr_q[7:1], busy};

   // busy counts down after a register write or one-time program
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sr_q <= `SR_RESET;
         cr_q <= `CR_RESET;
         sleep_q <= 1'b0;
         busy_q <= 8'h00;
      end else begin
         if (busy) busy_q <= busy_q - 8'h01;
         if (wrr_go) begin
            sr_q <= (sr_q & ~`SR_WRITE_MASK) | (wb0_q & `SR_WRITE_MASK);
            if (wcnt_q == 2'h2) cr_q <= wb1_q;
            busy_q <= 8'(`BUSY_CYCLES);
         end
         if (otp_go) begin
            busy_q <= 8'(`BUSY_CYCLES);
            if (otp_q[addr_q[`OTP_AW-1:0]] != `OTP_ERASED) sr_q[`SR_PROGRAM_FAIL_BIT] <= 1'b1;
         end
         if (exec && wcnt_q == 2'h0 && op_q == `OP_FAIL_FLAG_CLEAR) begin
            sr_q[`SR_ERASE_FAIL_BIT] <= 1'b0;
            sr_q[`SR_PROGRAM_FAIL_BIT] <= 1'b0;
         end
         if (exec && wcnt_q == 2'h0 && op_q == `OP_DEEP_SLEEP_ENTER) sleep_q <= 1'b1;
         if (cs_up && bit_q == 3'h0 && st_q == ST_DUMMY && byte_q == 2'h0 &&
             op_q == `OP_WAKE_AND_SIGNATURE) sleep_q <= 1'b0;
         if (byte_done && st_q == ST_DUMMY && op_q == `OP_WAKE_AND_SIGNATURE &&
             byte_q == 2'h2) sleep_q <= 1'b0;
      end
   end

   // one-time area: erased at reset, a programmed byte cannot be rewritten
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < `OTP_BYTES; i++) otp_q[i] <= `OTP_ERASED;
      end else if (otp_go && otp_q[addr_q[`OTP_AW-1:0]] == `OTP_ERASED) begin
         otp_q[addr_q[`OTP_AW-1:0]] <= wb0_q;
      end
   end

   // ************************************
   // output shifter
   // ************************************
   logic [7:0] osh_q, cur;
   logic [2:0] ocnt_q;
   logic [3:0] dout_q, oe_q;
   lanes_t lanes;

   // array content is a fixed pattern of the address; no program path here
   always_comb begin
      case (op_q)
         `OP_STATUS_FETCH: fetch = status;
         `OP_CONFIG_FETCH: fetch = cr_q;
         `OP_WAKE_AND_SIGNATURE: fetch = SIGNATURE;
         `OP_OTP_READ: fetch = otp_q[addr_q[`OTP_AW-1:0]];
         default: fetch = addr_q[7:0] ^ addr_q[15:8] ^ {2'h0, addr_q[21:16]};
      endcase
   end

   assign lanes = op_lanes(op_q);
   assign load = fall && st_q == ST_DOUT && ocnt_q == 3'h0;
   assign cur = (ocnt_q == 3'h0) ? fetch : osh_q;

   // each falling edge puts out the next one, two or four bits
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         osh_q <= 8'h00;
         ocnt_q <= 3'h0;
         dout_q <= 4'h0;
         oe_q <= 4'h0;
      end else if (cs_hi) begin
         ocnt_q <= 3'h0;
         oe_q <= 4'h0;
      end else if (fall && st_q == ST_DOUT) begin
         case (lanes)
            LANE_2: begin
               dout_q <= {2'h0, cur[7:6]};
               oe_q <= 4'h3;
               osh_q <= {cur[5:0], 2'h0};
               ocnt_q <= (ocnt_q == 3'h0) ? 3'h3 : ocnt_q - 3'h1;
            end
            LANE_4: begin
               dout_q <= cur[7:4];
               oe_q <= 4'hF;
               osh_q <= {cur[3:0], 4'h0};
               ocnt_q <= (ocnt_q == 3'h0) ? 3'h1 : ocnt_q - 3'h1;
            end
            default: begin
               dout_q <= {2'h0, cur[7], 1'b0};
               oe_q <= 4'h2;
               osh_q <= {cur[6:0], 1'b0};
               ocnt_q <= (ocnt_q == 3'h0) ? 3'h7 : ocnt_q - 3'h1;
            end
         endcase
      end
   end

   // enables drop in the very cycle the raised select is seen
   assign link.dev_oe = oe_q & {4{~cs_hi}};
   assign link.dev_io = dout_q;
   assign status_out = status;
   assign config_out = cr_q;
   assign sleep_out = sleep_q;
endmodule : flash_device
`default_nettype wire

/* File: src/flash_host.sv */
// flash host end: frames one command, collects read bytes into a buffer
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs.svh"
module flash_host (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   flash_if.host link,
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic [7:0] cmd_op_in,
   input wire logic [23:0] cmd_addr_in,
   input wire logic [15:0] cmd_wdata_in,
   input wire logic [1:0] cmd_wlen_in,
   input wire logic [15:0] cmd_rlen_in,
   output logic rd_valid_out,
   output logic [7:0] rd_data_out,
   input wire logic rd_ready_in,
   output logic done_out
);
   import flash_pkg::*;

   // ************************************
   // line synchroniser and clock divider
   // ************************************
   logic [3:0] s1_q, s2_q, s3_q, io_q;
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_q <= 4'hF;
         s2_q <= 4'hF;
         s3_q <= 4'hF;
         io_q <= 4'hF;
      end else begin
         s1_q <= link.io;
         s2_q <= s1_q;
         s3_q <= s2_q;
         io_q <= (s2_q & ~(s2_q ^ s3_q)) | (io_q & (s2_q ^ s3_q));
      end
   end

   host_state_t st_q;
   logic [39:0] tx_q, tx_d;
   logic [6:0] txleft_q;
   logic [15:0] rlen_q;
   logic [7:0] rx_q, rx_d;
   logic [2:0] ucnt_q, div_q;
   lanes_t lanes_q;
   logic cs_q, sck_q, tick, stall, push, sample;
   logic [3:0] nbytes;
   logic [7:0] mem_q [0:1];
   logic wp_q, rp_q;
   logic [1:0] cnt_q;

   // a full buffer holds the clock high so no received byte is lost
   assign sample = st_q == H_SHIFT && sck_q && txleft_q == 7'h00;
   assign stall = sample && ucnt_q == 3'h0 && cnt_q == 2'h2;
   assign tick = div_q == 3'(`SCK_HALF_CYCLES - 1) && !stall;
   assign push = tick && sample && ucnt_q == 3'h0;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) div_q <= 3'h0;
      else if (st_q == H_IDLE) div_q <= 3'h0;
      else if (!stall) div_q <= tick ? 3'h0 : div_q + 3'h1;
   end

   // ************************************
   // command framing
   // ************************************
   // opcode, address, write bytes, then zero dummy bytes, msb first
   always_comb begin
      tx_d = {cmd_op_in, 32'h00000000};
      nbytes = 4'h1 + {2'h0, cmd_wlen_in};
      if (op_has_addr(cmd_op_in)) begin
         tx_d[31:8] = cmd_addr_in;
         tx_d[7:0] = cmd_wdata_in[15:8];
         nbytes = nbytes + 4'h3;
      end else begin
         tx_d[31:16] = cmd_wdata_in;
      end
      if (cmd_op_in != `OP_WAKE_AND_SIGNATURE || cmd_rlen_in != 16'h0000) begin
         nbytes = nbytes + {2'h0, op_dummy(cmd_op_in)};
      end
   end

   always_comb begin
      case (lanes_q)
         LANE_2: rx_d = {rx_q[5:0], io_q[1:0]};
         LANE_4: rx_d = {rx_q[3:0], io_q};
         default: rx_d = {rx_q[6:0], io_q[1]};
      endcase
   end

   // falls after the last sent bit read back what the device put out before
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= H_IDLE;
         cs_q <= 1'b1;
         sck_q <= 1'b0;
         tx_q <= 40'h0000000000;
         txleft_q <= 7'h00;
         rlen_q <= 16'h0000;
         rx_q <= 8'h00;
         ucnt_q <= 3'h0;
         lanes_q <= LANE_1;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         case (st_q)
            H_IDLE: if (cmd_valid_in) begin
               st_q <= H_SHIFT;
               cs_q <= 1'b0;
               tx_q <= tx_d;
               txleft_q <= {nbytes, 3'h0};
               rlen_q <= cmd_rlen_in;
               lanes_q <= op_lanes(cmd_op_in);
               ucnt_q <= 3'h7 >> op_lanes(cmd_op_in);
            end
            H_SHIFT: if (tick) begin
               sck_q <= ~sck_q;
               if (sck_q && txleft_q != 7'h00) begin
                  tx_q <= {tx_q[38:0], 1'b0};
                  txleft_q <= txleft_q - 7'h01;
                  if (txleft_q == 7'h01 && rlen_q == 16'h0000) st_q <= H_END;
               end else if (sample) begin
                  rx_q <= rx_d;
                  ucnt_q <= (ucnt_q == 3'h0) ? 3'h7 >> lanes_q : ucnt_q - 3'h1;
                  if (ucnt_q == 3'h0) begin
                     rlen_q <= rlen_q - 16'h0001;
                     if (rlen_q == 16'h0001) st_q <= H_END;
                  end
               end
            end
            H_END: if (tick) begin
               cs_q <= 1'b1;
               st_q <= H_GAP;
            end
            H_GAP: if (tick) begin
               st_q <= H_IDLE;
               done_out <= 1'b1;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // ************************************
   // two-entry receive buffer
   // ************************************
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         mem_q[0] <= 8'h00;
         mem_q[1] <= 8'h00;
      end else begin
         if (push) begin
            mem_q[wp_q] <= rx_d;
            wp_q <= ~wp_q;
         end
         if (rd_valid_out && rd_ready_in) rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, rd_valid_out && rd_ready_in};
      end
   end

   // line 0 is released on the fall that ends the last sent bit
   assign link.host_oe = {3'h0, st_q == H_SHIFT && txleft_q != 7'h00};
   assign link.host_io = {3'h0, tx_q[39]};
   assign link.cs_n = cs_q;
   assign link.sck = sck_q;
   assign cmd_ready_out = st_q == H_IDLE;
   assign rd_valid_out = cnt_q != 2'h0;
   assign rd_data_out = mem_q[rp_q];
endmodule : flash_host
`default_nettype wire

/* File: src/flash_if.sv */
// serial flash link: chip select, clock and four shared data lines
`timescale 1ns/1ps
`default_nettype none
interface flash_if;
   logic cs_n;
   logic sck;
   logic [3:0] host_io;
   logic [3:0] host_oe;
   logic [3:0] dev_io;
   logic [3:0] dev_oe;
   logic [3:0] io;
   // pull-up on undriven lines; device wins on contention
   assign io = (dev_oe & dev_io) | (~dev_oe & host_oe & host_io) | (~dev_oe & ~host_oe);
   modport device (input cs_n, input sck, input io, output dev_io, output dev_oe);
   modport host (output cs_n, output sck, output host_io, output host_oe, input io);
endinterface : flash_if
`default_nettype wire

/* File: src/flash_pkg.sv */
// types and opcode helpers shared by both ends of the flash link
`include "flash_regs.svh"
package flash_pkg;
   typedef enum logic [5:0] {
      ST_CMD = 6'h01, ST_ADDR = 6'h02, ST_DUMMY = 6'h04,
      ST_DIN = 6'h08, ST_DOUT = 6'h10, ST_SKIP = 6'h20
   } dev_state_t;
   typedef enum logic [3:0] {
      H_IDLE = 4'h1, H_SHIFT = 4'h2, H_END = 4'h4, H_GAP = 4'h8
   } host_state_t;
   typedef enum logic [1:0] {LANE_1 = 2'h0, LANE_2 = 2'h1, LANE_4 = 2'h2} lanes_t;

   function automatic lanes_t op_lanes(input logic [7:0] op);
      if (op == `OP_TWO_LINE_READ) return LANE_2;
      if (op == `OP_FOUR_LINE_READ) return LANE_4;
      return LANE_1;
   endfunction : op_lanes

   function automatic logic [1:0] op_dummy(input logic [7:0] op);
      if (op == `OP_WAKE_AND_SIGNATURE) return 2'h3;
      if (op == `OP_FAST_READ || op == `OP_TWO_LINE_READ || op == `OP_FOUR_LINE_READ ||
          op == `OP_OTP_READ) return 2'h1;
      return 2'h0;
   endfunction : op_dummy

   function automatic logic op_has_addr(input logic [7:0] op);
      return op == `OP_READ || op == `OP_FAST_READ || op == `OP_TWO_LINE_READ ||
             op == `OP_FOUR_LINE_READ || op == `OP_OTP_READ || op == `OP_OTP_PROGRAM;
   endfunction : op_has_addr
endpackage : flash_pkg

/* File: src/flash_regs.svh */
// opcodes, register layout and timing constants of the serial flash link
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH
`define OP_STATUS_FETCH 8'h05
`define OP_CONFIG_FETCH 8'h35
`define OP_REGISTER_WRITE 8'h01
`define OP_FAIL_FLAG_CLEAR 8'h30
`define OP_DEEP_SLEEP_ENTER 8'hB9
`define OP_WAKE_AND_SIGNATURE 8'hAB
`define OP_OTP_PROGRAM 8'h42
`define OP_OTP_READ 8'h4B
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_TWO_LINE_READ 8'h3B
`define OP_FOUR_LINE_READ 8'h6B
`define SR_BUSY_BIT 0
`define SR_ERASE_FAIL_BIT 5
`define SR_PROGRAM_FAIL_BIT 6
`define SR_WRITE_MASK 8'h9C
`define SR_RESET 8'h00
`define CR_QUAD_ENABLE_BIT 1
`define CR_RESET 8'h00
`define ARRAY_TOP 24'h3FFFFF
`define OTP_AW 4
`define OTP_BYTES 16
`define OTP_ERASED 8'hFF
`define PIN_IDLE 6'h2F
`define REF_CLK_PERIOD_NS 10
`define BUSY_TIME_NS 640
`define BUSY_CYCLES ((`BUSY_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define SCK_HALF_NS 80
`define SCK_HALF_CYCLES (`SCK_HALF_NS / `REF_CLK_PERIOD_NS)
`endif

/* File: tb/flash_link_asserts.sv */
// concurrent checks on the wires between the flash host and device ends
`timescale 1ns/1ps
`default_nettype none
module flash_link_asserts (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] host_io,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_io,
   input wire logic [3:0] dev_oe
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   // ********************************
   // framing and clock shape
   // ********************************
   chk_clock_idle_low: assert property (cs_n |-> !sck)
      else $error("clock high while deselected");
   chk_select_setup: assert property ($fell(cs_n) |-> (host_oe[0] && !sck) [*8])
      else $error("no full low half after select");
   chk_low_half: assert property ($fell(sck) |-> (!sck) [*8])
      else $error("clock low half too short");
   // host data may only move while the clock is low, so rises see settled bits
   chk_host_data_hold: assert property (!cs_n && sck && host_oe[0] |-> $stable(host_io[0]))
      else $error("host data moved while clock high");
   chk_host_one_line: assert property (host_oe[3:1] == 3'h0)
      else $error("host drove a line other than serial input");
   // ********************************
   // device output lanes
   // ********************************
   chk_no_contention: assert property ((host_oe & dev_oe) == 4'h0)
      else $error("host and device drive one line");
   chk_lane_shape: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("device enables an odd set of lines");
   chk_quiet_deselect: assert property (cs_n [*6] |-> dev_oe == 4'h0)
      else $error("device still drives after deselect");
   chk_out_on_fall: assert property (dev_oe != 4'h0 && $changed(dev_io) |-> !sck)
      else $error("device data moved while clock high");
   chk_end_on_low: assert property ($rose(cs_n) |-> !$past(sck, 1) && !$past(sck, 7))
      else $error("deselect without a low half");
endmodule : flash_link_asserts
`default_nettype wire

/* File: tb/serial_flash_read_and_status_commands_tb.sv */
// bench: host and device ends joined, plus a rule-breaking driver on a second link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_and_status_commands_tb;
   localparam logic [7:0] SIG = 8'hC3; // arbitrary value
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic cmd_valid_in = 1'b0;
   logic cmd_ready_out;
   logic [7:0] cmd_op_in = 8'h00;
   logic [23:0] cmd_addr_in = 24'h000000;
   logic [15:0] cmd_wdata_in = 16'h0000;
   logic [1:0] cmd_wlen_in = 2'h0;
   logic [15:0] cmd_rlen_in = 16'h0000;
   logic rd_valid_out;
   logic rd_ready_in = 1'b0;
   logic [7:0] rd_data_out;
   logic done_out;
   logic [7:0] status_out;
   logic [7:0] config_out;
   logic sleep_out;
   logic sleep2;
   logic [7:0] sleep_op = 8'hB9;
   logic [7:0] rops [4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
   logic [7:0] got [$];
   int n_fail = 0;
   int cmp_count = 0;
   flash_if f ();
   flash_if g ();
   flash_host flash_host_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(f),
      .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in),
      .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in), .cmd_wlen_in(cmd_wlen_in),
      .cmd_rlen_in(cmd_rlen_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
      .rd_ready_in(rd_ready_in), .done_out(done_out));
   flash_device #(.SIGNATURE(SIG)) flash_device_inst (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .link(f), .status_out(status_out), .config_out(config_out),
      .sleep_out(sleep_out));
   // second device sees only the bench's own bit-banged frames
   flash_device #(.SIGNATURE(SIG)) flash_device_fault_inst (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .link(g), .status_out(), .config_out(), .sleep_out(sleep2));
   flash_link_asserts flash_link_asserts_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .cs_n(f.cs_n), .sck(f.sck), .host_io(f.host_io), .host_oe(f.host_oe),
      .dev_io(f.dev_io), .dev_oe(f.dev_oe));
   // 100 MHz reference clock
   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // ********************************
   // helpers
   // ********************************
   function automatic logic [7:0] arr(input logic [23:0] a);
      logic [23:0] m;
      m = a & 24'h3FFFFF;
      return m[7:0] ^ m[15:8] ^ m[23:16];
   endfunction : arr
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one framed command; the reader holds ready low for hold cycles to stall
   task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [15:0] wd,
         input logic [1:0] wl, input logic [15:0] rl, input int hold);
      logic d;
      got.delete();
      d = 1'b0;
      for (int k = 0; cmd_ready_out !== 1'b1; k++) begin
         if (k > 100) begin
            n_fail++;
            report_and_stop();
         end
         @(negedge ref_clk_in);
      end
      cmd_op_in = op;
      cmd_addr_in = a;
      cmd_wdata_in = wd;
      cmd_wlen_in = wl;
      cmd_rlen_in = rl;
      cmd_valid_in = 1'b1;
      @(negedge ref_clk_in);
      cmd_valid_in = 1'b0;
      for (int k = 0; k < 30000; k++) begin
         @(negedge ref_clk_in);
         rd_ready_in = (k >= hold);
         if (rd_valid_out === 1'b1 && rd_ready_in) got.push_back(rd_data_out);
         d = d | (done_out === 1'b1);
         if (d && rd_valid_out !== 1'b1) begin
            chk("bytes", 8'(got.size()), 8'(rl));
            return;
         end
      end
      n_fail++;
      report_and_stop();
   endtask : run
   task automatic fetch(input logic [7:0] op, input logic [7:0] exp);
      run(op, 24'h0, 16'h0, 2'h0, 16'h2, 0);
      chk("reg byte", got[0], exp);
      chk("reg again", got[1], exp);
   endtask : fetch
   task automatic settle;
      repeat (70) @(negedge ref_clk_in);
   endtask : settle
   // sleep command cut to n clocks on the second link
   task automatic bang(input int n);
      g.cs_n = 1'b0;
      g.host_oe = 4'h1;
      for (int i = 0; i < n; i++) begin
         g.host_io[0] = sleep_op[7 - i % 8];
         repeat (8) @(negedge ref_clk_in);
         g.sck = 1'b1;
         repeat (8) @(negedge ref_clk_in);
         g.sck = 1'b0;
      end
      repeat (8) @(negedge ref_clk_in);
      g.cs_n = 1'b1;
      g.host_oe = 4'h0;
      repeat (16) @(negedge ref_clk_in);
   endtask : bang
   // ********************************
   // main sequence
   // ********************************
   initial begin
      g.cs_n = 1'b1;
      g.sck = 1'b0;
      g.host_io = 4'h0;
      g.host_oe = 4'h0;
      repeat (8) @(negedge ref_clk_in);
      resetn_in = 1'b1;
      fetch(8'h05, 8'h00);
      fetch(8'h35, 8'h00);
      run(8'h01, 24'h0, 16'hFF02, 2'h2, 16'h0, 0);
      chk("busy", status_out, 8'h9D);
      settle();
      fetch(8'h05, 8'h9C);
      fetch(8'h35, 8'h02);
      chk("config", config_out, 8'h02);
      $display("test registers done");
      // first read stalls the reader long enough to fill the buffer
      foreach (rops[i]) begin
         run(rops[i], 24'h3FFFFE, 16'h0, 2'h0, 16'h3, i == 0 ? 1500 : 0);
         for (int j = 0; j < 3; j++) chk("array", got[j], arr(24'(24'h3FFFFE + j)));
      end
      run(8'h01, 24'h0, 16'h9C00, 2'h2, 16'h0, 0);
      settle();
      run(8'h6B, 24'h0, 16'h0, 2'h0, 16'h1, 0);
      chk("quad off", got[0], 8'hFF);
      $display("test reads done");
      run(8'h4B, 24'h5, 16'h0, 2'h0, 16'h1, 0);
      chk("otp blank", got[0], 8'hFF);
      run(8'h42, 24'h5, 16'hA500, 2'h1, 16'h0, 0);
      settle();
      run(8'h4B, 24'h5, 16'h0, 2'h0, 16'h2, 0);
      chk("otp", got[0], 8'hA5);
      chk("otp next", got[1], 8'hFF);
      run(8'h42, 24'h5, 16'h3C00, 2'h1, 16'h0, 0);
      settle();
      chk("fail flag", status_out, 8'hDC);
      run(8'h30, 24'h0, 16'h0, 2'h0, 16'h0, 0);
      chk("flag clear", status_out, 8'h9C);
      $display("test otp done");
      run(8'hB9, 24'h0, 16'h0, 2'h0, 16'h0, 0);
      chk("asleep", sleep_out, 1'b1);
      fetch(8'h05, 8'hFF);
      run(8'hAB, 24'h0, 16'h0, 2'h0, 16'h0, 0);
      chk("awake", sleep_out, 1'b0);
      run(8'hB9, 24'h0, 16'h0, 2'h0, 16'h0, 0);
      run(8'hAB, 24'h0, 16'h0, 2'h0, 16'h2, 0);
      chk("signature", got[0], SIG);
      chk("signature again", got[1], SIG);
      chk("woken", sleep_out, 1'b0);
      // a single data byte loads status only and leaves config alone
      run(8'h01, 24'h0, 16'h1000, 2'h1, 16'h0, 0);
      settle();
      chk("one byte write", status_out, 8'h10);
      chk("config kept", config_out, 8'h00);
      bang(7);
      chk("short frame", sleep2, 1'b0);
      bang(8);
      chk("whole frame", sleep2, 1'b1);
      $display("test power done");
      report_and_stop();
   end
endmodule : serial_flash_read_and_status_commands_tb
`default_nettype wire
